// >>> verilog/ortx_top.v
// Octal registered bus transceiver with an APB status and control port.
module ortx_top #(
  parameter WIDTH = 8
) (
  input  wire             i_sys_clk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_left_bus_bits,
  output reg  [WIDTH-1:0] o_left_bus_bits,
  output reg              o_left_bus_oe_n,
  input  wire [WIDTH-1:0] i_right_bus_bits,
  output reg  [WIDTH-1:0] o_right_bus_bits,
  output reg              o_right_bus_oe_n,
  input  wire             i_a_to_b_capture_clock,
  input  wire             i_b_to_a_capture_clock,
  input  wire             i_a_to_b_source_select,
  input  wire             i_b_to_a_source_select,
  input  wire             i_b_port_drive_enable,
  input  wire             i_a_port_drive_enable_n,
  input  wire             i_psel,
  input  wire             i_penable,
  input  wire             i_pwrite,
  input  wire [11:0]      i_paddr,
  input  wire [31:0]      i_pwdata,
  output reg  [31:0]      o_prdata,
  output reg              o_pready,
  output reg              o_pslverr
);

`include "ortx_regs.vh"

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function rise;
    input cur;
    input prev;
    begin
      rise = cur & ~prev;
    end
  endfunction

  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr == `ORTX_OFS_CTRL) || (addr == `ORTX_OFS_STORE) ||
               (addr == `ORTX_OFS_PINS);
    end
  endfunction

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  // Every bus and control pin is asynchronous to the system clock, so the live path has
  // three cycles of latency instead of a true combinational feed-through.
  reg [WIDTH-1:0] left_s1_r;
  reg [WIDTH-1:0] left_s2_r;
  reg [WIDTH-1:0] right_s1_r;
  reg [WIDTH-1:0] right_s2_r;
  reg [5:0]       ctl_s1_r;
  reg [5:0]       ctl_s2_r;
  reg [1:0]       clk_prev_r;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      left_s1_r  <= `ORTX_RST_DATA;
      left_s2_r  <= `ORTX_RST_DATA;
      right_s1_r <= `ORTX_RST_DATA;
      right_s2_r <= `ORTX_RST_DATA;
      // The left enable is active low, so its stages clear to the
      // disabled level; otherwise the left port would drive for two
      // cycles after reset while the synchroniser refills.
      ctl_s1_r   <= 6'h20;
      ctl_s2_r   <= 6'h20;
      clk_prev_r <= 2'h3;
    end else begin
      left_s1_r  <= i_left_bus_bits;
      left_s2_r  <= left_s1_r;
      right_s1_r <= i_right_bus_bits;
      right_s2_r <= right_s1_r;
      ctl_s1_r   <= {i_a_port_drive_enable_n, i_b_port_drive_enable,
                     i_b_to_a_source_select, i_a_to_b_source_select,
                     i_b_to_a_capture_clock, i_a_to_b_capture_clock};
      ctl_s2_r   <= ctl_s1_r;
      clk_prev_r <= ctl_s2_r[1:0];
    end
  end

  wire a_to_b_capture_clock_s  = ctl_s2_r[`ORTX_PINS_A_TO_B_CAPTURE_CLOCK];
  wire b_to_a_capture_clock_s  = ctl_s2_r[`ORTX_PINS_B_TO_A_CAPTURE_CLOCK];
  wire sab_s   = ctl_s2_r[`ORTX_PINS_SAB];
  wire sba_s   = ctl_s2_r[`ORTX_PINS_SBA];
  wire b_port_drive_enable_s  = ctl_s2_r[`ORTX_PINS_B_PORT_DRIVE_ENABLE];
  wire a_port_drive_enable_n_ns = ctl_s2_r[`ORTX_PINS_A_PORT_DRIVE_ENABLE_N_N];
  wire cap_ab  = rise(a_to_b_capture_clock_s, clk_prev_r[0]);
  wire cap_ba  = rise(b_to_a_capture_clock_s, clk_prev_r[1]);

  // ******************************************************************
  // APB slave
  // ******************************************************************
  wire setup  = i_psel & ~i_penable & ~o_pready;
  wire wr_acc = i_psel & i_penable & o_pready & i_pwrite &
                (i_paddr == `ORTX_OFS_CTRL);
  wire clr_ab = wr_acc & i_pwdata[`ORTX_CTRL_CLR_AB];
  wire clr_ba = wr_acc & i_pwdata[`ORTX_CTRL_CLR_BA];

  reg [WIDTH-1:0] store_ab_r;
  reg [WIDTH-1:0] store_ba_r;
  reg [31:0]      rdata_nxt;

  always @* begin
    rdata_nxt = 32'h00000000;
    if (!i_pwrite) begin
      case (i_paddr)
        `ORTX_OFS_STORE: begin
          rdata_nxt[`ORTX_STORE_AB_LSB +: WIDTH] = store_ab_r;
          rdata_nxt[`ORTX_STORE_BA_LSB +: WIDTH] = store_ba_r;
        end
        `ORTX_OFS_PINS: begin
          rdata_nxt[5:0] = ctl_s2_r;
        end
        default: begin
          rdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_pready  <= 1'h0;
      o_pslverr <= 1'h0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~mapped(i_paddr);
      o_prdata  <= setup ? rdata_nxt : 32'h00000000;
    end
  end

  // ******************************************************************
  // Store registers
  // ******************************************************************
  // A capture edge wins over a software clear in the same cycle, so no
  // bus sample is lost. Whatever level sits on the pins is taken, which
  // is how a port driven by this block loads the driven value.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      store_ab_r <= `ORTX_RST_STORE;
      store_ba_r <= `ORTX_RST_STORE;
    end else begin
      if (cap_ab) begin
        store_ab_r <= left_s2_r;
      end else if (clr_ab) begin
        store_ab_r <= `ORTX_RST_STORE;
      end
      if (cap_ba) begin
        store_ba_r <= right_s2_r;
      end else if (clr_ba) begin
        store_ba_r <= `ORTX_RST_STORE;
      end
    end
  end

  // ******************************************************************
  // Port drivers
  // ******************************************************************
  // Output enables are low while the pins are driven. The selects only
  // steer the data mux and never touch the enables.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_right_bus_oe_n <= `ORTX_RST_OE_N;
      o_left_bus_oe_n  <= `ORTX_RST_OE_N;
      o_right_bus_bits <= `ORTX_RST_DATA;
      o_left_bus_bits  <= `ORTX_RST_DATA;
    end else begin
      o_right_bus_oe_n <= ~b_port_drive_enable_s;
      o_left_bus_oe_n  <= a_port_drive_enable_n_ns;
      o_right_bus_bits <= sab_s ? store_ab_r : left_s2_r;
      o_left_bus_bits  <= sba_s ? store_ba_r : right_s2_r;
    end
  end

endmodule

// >>> verilog/ortx_regs.vh
// Register offsets, field positions and reset values of the transceiver.
`ifndef ORTX_REGS_VH
`define ORTX_REGS_VH

// ********************************************************************
// Register offsets (byte addresses)
// ********************************************************************
`define ORTX_OFS_CTRL      12'h000
`define ORTX_OFS_STORE     12'h004
`define ORTX_OFS_PINS      12'h008

// ********************************************************************
// Field positions
// ********************************************************************
`define ORTX_CTRL_CLR_AB   0
`define ORTX_CTRL_CLR_BA   1
`define ORTX_STORE_AB_LSB  0
`define ORTX_STORE_BA_LSB  8
`define ORTX_PINS_A_TO_B_CAPTURE_CLOCK     0
`define ORTX_PINS_B_TO_A_CAPTURE_CLOCK     1
`define ORTX_PINS_SAB      2
`define ORTX_PINS_SBA      3
`define ORTX_PINS_B_PORT_DRIVE_ENABLE     4
`define ORTX_PINS_A_PORT_DRIVE_ENABLE_N_N   5

// ********************************************************************
// Reset values
// ********************************************************************
`define ORTX_RST_STORE     8'h00
`define ORTX_RST_OE_N      1'h1
`define ORTX_RST_DATA      8'h00

`endif

// >>> verification/ortx_chk_assertions.sv
// Port checks of the transceiver, bound onto its top module.
module ortx_chk (
  input wire       i_sys_clk, i_rst_n, i_psel, o_pready, o_left_bus_oe_n,
  input wire       o_right_bus_oe_n, i_a_to_b_capture_clock,
  input wire       i_b_to_a_capture_clock, i_a_to_b_source_select,
  input wire       i_b_to_a_source_select, i_b_port_drive_enable,
  input wire       i_a_port_drive_enable_n,
  input wire [7:0] i_left_bus_bits, i_right_bus_bits, o_left_bus_bits,
  input wire [7:0] o_right_bus_bits
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_right_oe_map: assert property (o_right_bus_oe_n ==
    !$past(i_b_port_drive_enable, 3)) else $error("r oe");
  chk_left_oe_map: assert property (o_left_bus_oe_n ==
    $past(i_a_port_drive_enable_n, 3)) else $error("l oe");
  chk_right_live: assert property (
    $past(i_b_port_drive_enable, 3) && !$past(i_a_to_b_source_select, 3)
    |-> o_right_bus_bits == $past(i_left_bus_bits, 3)) else $error("r live");
  chk_left_live: assert property (
    !$past(i_a_port_drive_enable_n, 3) && !$past(i_b_to_a_source_select, 3)
    |-> o_left_bus_bits == $past(i_right_bus_bits, 3)) else $error("l live");
  chk_right_hold: assert property ((i_a_to_b_source_select &&
    i_b_port_drive_enable && !i_a_to_b_capture_clock) [*8] |->
    $stable(o_right_bus_bits)) else $error("r hold");
  chk_left_hold: assert property ((i_b_to_a_source_select &&
    !i_a_port_drive_enable_n && !i_b_to_a_capture_clock) [*8] |->
    $stable(o_left_bus_bits)) else $error("l hold");
  chk_reset_idle: assert property (disable iff (1'b0)
    !i_rst_n |=> o_left_bus_oe_n && o_right_bus_oe_n) else $error("rst");
  chk_apb_answer: assert property (i_psel && !o_pready |=> o_pready)
    else $error("apb wait");
endmodule
bind ortx_top ortx_chk u_chk (.*);

// >>> verification/ortx_bus_model.sv
// Far-side data bus model for one port of the transceiver.
module ortx_bus_model (
  input  wire [7:0] i_dev, i_ext,
  input  wire       i_oe_n,
  output wire [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // The outside driver stands aside while the device drives, so no
  // contention has to be resolved on the wire.
  assign o_pin = i_oe_n ? i_ext : i_dev;
endmodule

// >>> verification/tb.sv
// Self-checking bench of the transceiver.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk = 0, rst_n = 0, cab = 0, cba = 0, a_to_b_source_select = 0, b_to_a_source_select = 0;
  reg         en = 0, en_n = 1, psel = 0, pen = 0, pwr = 0, er;
  reg  [7:0]  lx = 0, rx = 0;
  reg  [11:0] pa = 0;
  reg  [31:0] pwd = 0, rd;
  wire [7:0]  lp, rp, lo, ro;
  wire        loe, roe, prdy, perr;
  wire [31:0] prd;
  integer     err_count = 0, n_tests = 0, k;
  always #5 clk = ~clk;
  ortx_top u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_left_bus_bits(lp),
    .o_left_bus_bits(lo), .o_left_bus_oe_n(loe), .i_right_bus_bits(rp),
    .o_right_bus_bits(ro), .o_right_bus_oe_n(roe),
    .i_a_to_b_capture_clock(cab), .i_b_to_a_capture_clock(cba),
    .i_a_to_b_source_select(a_to_b_source_select), .i_b_to_a_source_select(b_to_a_source_select),
    .i_b_port_drive_enable(en), .i_a_port_drive_enable_n(en_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr));
  ortx_bus_model u_lbus (.i_dev(lo), .i_oe_n(loe), .i_ext(lx), .o_pin(lp));
  ortx_bus_model u_rbus (.i_dev(ro), .i_oe_n(roe), .i_ext(rx), .o_pin(rp));
  task wt(input integer n); repeat (n) @(posedge clk); endtask
  task chk(input [31:0] g, e);
    n_tests = n_tests + 1;
    if (g !== e) begin err_count = err_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e); end
  endtask
  task conclude;
    $display("%0d compares, %0d errors", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    wt(1); psel <= 1; pwr <= w; pa <= a; pwd <= d;
    wt(1); pen <= 1;
    for (k = 0; k < 9 && prdy !== 1'b1; k = k + 1) wt(1);
    rd = prd; er = perr; psel <= 0; pen <= 0;
    chk(k < 9, 1); if (k == 9) conclude;
  endtask
  task setp(input e, n, sa, sb, input [7:0] l, r);
    en <= e; en_n <= n; a_to_b_source_select <= sa; b_to_a_source_select <= sb; lx <= l; rx <= r; wt(7);
  endtask
  task cap(input a, b);
    cab <= a; cba <= b; wt(3); cab <= 0; cba <= 0; wt(7);
  endtask
  task t_reset;
    chk({loe, roe, lo, ro}, 18'h30000);
    apb(0, 12'h4, 0); chk(rd, 0);
    $display("reset test done");
  endtask
  task t_a2b;
    setp(1, 1, 0, 0, 8'ha5, 8'h00); cap(1, 1);
    chk(rp, 8'ha5);
    apb(0, 12'h4, 0); chk(rd, 32'ha5a5);
    $display("a to b test done");
  endtask
  task t_b2a;
    setp(0, 0, 0, 0, 8'h00, 8'hc3); cap(1, 1);
    chk(lp, 8'hc3);
    apb(0, 12'h4, 0); chk(rd, 32'hc3c3);
    $display("b to a test done");
  endtask
  task t_clr;
    apb(1, 12'h0, 3); apb(0, 12'h4, 0); chk(rd, 0);
    apb(0, 12'h0f0, 0); chk(er, 1); chk(rd, 0);
    $display("register test done");
  endtask
  task t_iso;
    setp(0, 1, 1, 1, 8'h11, 8'h22); cap(1, 0); cap(0, 1);
    chk({loe, roe}, 2'b11);
    apb(0, 12'h4, 0); chk(rd, 32'h2211);
    setp(1, 0, 1, 1, 8'h11, 8'h22); chk({lp, rp}, 16'h2211);
    apb(0, 12'h8, 0); chk(rd, 32'h1c);
    chk({lp, rp}, 16'h2211);
    $display("stored test done");
  endtask
  initial begin
    wt(12); rst_n <= 1; wt(2);
    t_reset; t_a2b; t_b2a; t_clr; t_iso;
    conclude;
  end
endmodule
